// ---- hub_strap_pkg.sv ----
// Constants, field layouts and types for the hub strap and indicator block.
// Assumes a single 40 MHz system clock and an Avalon-MM register master.
package hub_strap_pkg;

	// Number of downstream ports and how many of them can never be disabled.
	localparam int NUM_PORTS   = 7;
	localparam int FIXED_PORTS = 2;

	// Clock rate and the link indicator blink-off time in its own unit.
	localparam int CLK_HZ       = 40_000_000;
	localparam int BLINK_OFF_MS = 100;
	// Blink time in clock cycles, derived from the rate.
	localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_OFF_MS;

	// Register byte offsets on the Avalon-MM port.
	localparam logic [3:0] LED_CTRL_OFS   = 4'h0;
	localparam logic [3:0] STRAP_STAT_OFS = 4'h4;
	localparam logic [3:0] OC_STAT_OFS    = 4'h8;

	// Field positions inside the LED control register.
	localparam int GREEN_POS = 0;
	localparam int AMBER_POS = 8;

	// Field positions inside the strap status register.
	localparam int EN_POS      = 0;
	localparam int COUNT_POS   = 8;
	localparam int NO_OC_POS   = 12;
	localparam int ANALOG_POS  = 13;
	localparam int SAMPLED_POS = 14;
	localparam int GSTRAP_POS  = 16;
	localparam int ASTRAP_POS  = 24;

	// Reset value of the LED control register: all port LEDs dark.
	localparam logic [31:0] LED_CTRL_RST = 32'h0000_0000;

	// Configuration caught from the pins once after reset.
	typedef struct packed {
		logic [NUM_PORTS-1:0] amber_strap;
		logic [NUM_PORTS-1:0] green_strap;
		logic                 analog;
		logic                 no_oc;
		logic [NUM_PORTS-1:0] enabled;
	} strap_t;

	// Link activity indicator states.
	typedef enum logic [1:0] {
		LINK_DARK,
		LINK_ON,
		LINK_BLINK
	} link_state_t;

endpackage : hub_strap_pkg

// ---- hub_strap_and_led_indicators.sv ----
// Strap sampling, overcurrent mode selection and LED drive for a seven-port hub.
// Assumes synchronous pin inputs, one 40 MHz clock and an Avalon-MM master.
`timescale 1ns/100ps

module hub_strap_and_led_indicators
	import hub_strap_pkg::*;
#(
	parameter int BLINK_LEN = BLINK_CYCLES
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic                 no_overcurrent_select,
	input  wire logic                 overcurrent_analog_select,
	input  wire logic [NUM_PORTS-1:0] overcurrent_sense_n,
	input  wire logic [NUM_PORTS-1:0] port_dplus_line,
	input  wire logic [NUM_PORTS-1:0] port_dminus_line,
	input  wire logic                 hub_configured,
	input  wire logic                 hub_suspended,
	input  wire logic                 host_transaction,
	input  wire logic [NUM_PORTS-1:0] port_green_led_n_i,
	output logic      [NUM_PORTS-1:0] port_green_led_n_o,
	output logic      [NUM_PORTS-1:0] port_green_led_n_oe_n,
	input  wire logic [NUM_PORTS-1:0] port_amber_led_n_i,
	output logic      [NUM_PORTS-1:0] port_amber_led_n_o,
	output logic      [NUM_PORTS-1:0] port_amber_led_n_oe_n,
	output logic                      link_activity_led_n_o,
	output logic                      link_activity_led_n_oe_n,
	output logic      [NUM_PORTS-1:0] overcurrent_flags,
	output logic                      overcurrent_analog_mode
);

	// Counter width sized to hold the whole blink interval.
	localparam int CNT_W = $clog2(BLINK_LEN + 1);
	localparam logic [CNT_W-1:0] BLINK_LOAD = CNT_W'(BLINK_LEN - 1);

	// A zero-length blink or one past the counter range cannot be timed.
	if (BLINK_LEN < 1 || BLINK_LEN > 8_388_607) begin : g_bad_len
		$error("BLINK_LEN out of range");
	end

	// Counts the enabled ports as the block starting at port one.
	function automatic logic [2:0] count_ports(input logic [NUM_PORTS-1:0] en);
		logic [2:0] n;
		logic       run;
		n   = 3'h0;
		run = 1'b1;
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			run = run & en[i];
			if (run)
				n = n + 3'h1;
		end
		return n;
	endfunction : count_ports

	strap_t               strap_q, strap_d;       // Caught pin configuration.
	logic                 sampled_q, sampled_d;   // Straps have been caught.
	logic [NUM_PORTS-1:0] oc_q, oc_d;             // Effective overcurrent flags.
	logic                 analog_q, analog_d;     // Analog sensing mode.
	logic [31:0]          ctrl_q, ctrl_d;         // LED control register.
	logic [31:0]          rdata_q, rdata_d;       // Read data register.
	logic                 wait_q, wait_d;         // Waitrequest register.
	logic [NUM_PORTS-1:0] green_oe_n_q, green_oe_n_d;
	logic [NUM_PORTS-1:0] amber_oe_n_q, amber_oe_n_d;
	logic [NUM_PORTS-1:0] pin_low_q;              // Open-drain pins only ever pull low.
	link_state_t          link_q, link_d;         // Link indicator state.
	logic [CNT_W-1:0]     blink_cnt_q, blink_cnt_d;
	logic                 link_oe_n_q, link_oe_n_d;
	logic                 link_low_q;

	// Catch straps once, on the first edge after reset release, while pins float.
	always_comb
	begin
		sampled_d = 1'b1;
		strap_d   = strap_q;
		if (!sampled_q)
		begin
			strap_d.green_strap = port_green_led_n_i;
			strap_d.amber_strap = port_amber_led_n_i;
			strap_d.analog      = overcurrent_analog_select;
			strap_d.no_oc       = no_overcurrent_select;
			for (int i = 0; i < NUM_PORTS; i++)
			begin
				// Low ports ignore the disable strap entirely.
				strap_d.enabled[i] = (i < FIXED_PORTS) ? 1'b1 :
					!(port_dplus_line[i] & port_dminus_line[i]);
			end
		end
	end

	// Overcurrent flags follow the sense pins of enabled ports unless protection is strapped off.
	always_comb
	begin
		analog_d = strap_q.analog;
		oc_d     = '0;
		if (sampled_q && !strap_q.no_oc)
			oc_d = ~overcurrent_sense_n & strap_q.enabled;
	end

	// Avalon-MM slave: one wait cycle, then a single-cycle acknowledge.
	always_comb
	begin
		wait_d  = 1'b1;
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		if ((avs_read || avs_write) && wait_q)
		begin
			wait_d = 1'b0;
			rdata_d = 32'h0000_0000;
			if (avs_read)
			begin
				unique case (avs_address)
					LED_CTRL_OFS:   rdata_d = ctrl_q;
					STRAP_STAT_OFS:
					begin
						rdata_d[EN_POS +: NUM_PORTS]     = strap_q.enabled;
						rdata_d[COUNT_POS +: 3]          = count_ports(strap_q.enabled);
						rdata_d[NO_OC_POS]               = strap_q.no_oc;
						rdata_d[ANALOG_POS]              = strap_q.analog;
						rdata_d[SAMPLED_POS]             = sampled_q;
						rdata_d[GSTRAP_POS +: NUM_PORTS] = strap_q.green_strap;
						rdata_d[ASTRAP_POS +: NUM_PORTS] = strap_q.amber_strap;
					end
					OC_STAT_OFS:    rdata_d[NUM_PORTS-1:0] = oc_q;
					default:        rdata_d = 32'h0000_0000;  // Unmapped reads zero.
				endcase
			end
		end
		// A write lands on the acknowledging edge, where the transfer completes.
		if (avs_write && !wait_q && avs_address == LED_CTRL_OFS)
		begin
			for (int b = 0; b < 4; b++)
				if (avs_byteenable[b])
					ctrl_d[b*8 +: 8] = avs_writedata[b*8 +: 8];
		end
	end

	// Port LEDs stay released until straps are caught; absent ports never light.
	always_comb
	begin
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			green_oe_n_d[i] = !(sampled_q && strap_q.enabled[i] &&
				ctrl_q[GREEN_POS + i]);
			amber_oe_n_d[i] = !(sampled_q && strap_q.enabled[i] &&
				ctrl_q[AMBER_POS + i]);
		end
	end

	// Link indicator: suspend and unconfigured force dark, traffic blinks it off.
	always_comb
	begin
		link_d      = link_q;
		blink_cnt_d = blink_cnt_q;
		if (!hub_configured || hub_suspended)
		begin
			link_d      = LINK_DARK;
			blink_cnt_d = '0;
		end
		else if (host_transaction)
		begin
			link_d      = LINK_BLINK;
			blink_cnt_d = BLINK_LOAD;
		end
		else
		begin
			unique case (link_q)
				LINK_DARK:  link_d = LINK_ON;
				LINK_ON:    link_d = LINK_ON;
				LINK_BLINK:
				begin
					if (blink_cnt_q == '0)
						link_d = LINK_ON;
					else
						blink_cnt_d = blink_cnt_q - CNT_W'(1);
				end
				default:    link_d = LINK_DARK;  // The unused code falls back to dark.
			endcase
		end
		link_oe_n_d = (link_d != LINK_ON);
	end

	// All state registers; reset loads constants only.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			strap_q      <= '0;
			sampled_q    <= 1'b0;
			oc_q         <= '0;
			analog_q     <= 1'b0;
			ctrl_q       <= LED_CTRL_RST;
			rdata_q      <= 32'h0000_0000;
			wait_q       <= 1'b1;
			green_oe_n_q <= '1;
			amber_oe_n_q <= '1;
			pin_low_q    <= '0;
			link_q       <= LINK_DARK;
			blink_cnt_q  <= '0;
			link_oe_n_q  <= 1'b1;
			link_low_q   <= 1'b0;
		end
		else
		begin
			strap_q      <= strap_d;
			sampled_q    <= sampled_d;
			oc_q         <= oc_d;
			analog_q     <= analog_d;
			ctrl_q       <= ctrl_d;
			rdata_q      <= rdata_d;
			wait_q       <= wait_d;
			green_oe_n_q <= green_oe_n_d;
			amber_oe_n_q <= amber_oe_n_d;
			pin_low_q    <= '0;
			link_q       <= link_d;
			blink_cnt_q  <= blink_cnt_d;
			link_oe_n_q  <= link_oe_n_d;
			link_low_q   <= 1'b0;
		end
	end

	// Outputs come straight from the registers above.
	assign avs_readdata             = rdata_q;
	assign avs_waitrequest          = wait_q;
	assign port_green_led_n_o       = pin_low_q;
	assign port_green_led_n_oe_n    = green_oe_n_q;
	assign port_amber_led_n_o       = pin_low_q;
	assign port_amber_led_n_oe_n    = amber_oe_n_q;
	assign link_activity_led_n_o    = link_low_q;
	assign link_activity_led_n_oe_n = link_oe_n_q;
	assign overcurrent_flags        = oc_q;
	assign overcurrent_analog_mode  = analog_q;

	// Checks on the behaviour above.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	link_unconf_a: assert property (!hub_configured |=> link_oe_n_q)
		else $error("link LED lit while unconfigured");
	link_suspend_a: assert property (hub_suspended |=> link_oe_n_q)
		else $error("link LED lit in suspend");
	blink_start_a: assert property
		(hub_configured && !hub_suspended && host_transaction |=> link_oe_n_q
			&& blink_cnt_q == BLINK_LOAD)
		else $error("transaction did not start blink");
	blink_end_a: assert property
		(link_q == LINK_BLINK && blink_cnt_q == '0 && hub_configured && !hub_suspended
			&& !host_transaction |=> !link_oe_n_q)
		else $error("blink did not end");
	blink_count_a: assert property
		(link_q == LINK_BLINK && blink_cnt_q != '0 && hub_configured && !hub_suspended
			&& !host_transaction |=> blink_cnt_q == $past(blink_cnt_q) - CNT_W'(1))
		else $error("blink counter stalled");
	fixed_ports_a: assert property (sampled_q |-> &strap_q.enabled[FIXED_PORTS-1:0])
		else $error("fixed port disabled");
	no_oc_mask_a: assert property (sampled_q && strap_q.no_oc |=> oc_q == '0)
		else $error("overcurrent not masked");
	absent_dark_a: assert property
		(sampled_q |=> ((~strap_q.enabled) & ~(green_oe_n_q & amber_oe_n_q)) == '0)
		else $error("absent port LED driven");
	strap_first_a: assert property
		(!sampled_q |=> &green_oe_n_q && &amber_oe_n_q)
		else $error("LED driven before strap catch");
	bus_ack_a: assert property
		((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
		else $error("bus acknowledge not one cycle");

	blink_c:  cover property (link_q == LINK_BLINK ##1 link_q == LINK_ON);
	oc_c:     cover property (oc_q != '0);
	absent_c: cover property (sampled_q && !strap_q.enabled[NUM_PORTS-1]);

endmodule : hub_strap_and_led_indicators

// ---- board_model.sv ----
// Board model: strap resistors on the port data lines and the LED pins.
// Assumes the bench picks the strap values and holds them across reset.
`timescale 1ns/100ps

module board_model
	import hub_strap_pkg::*;
(
	input  wire logic [2:0]           n_off,
	input  wire logic                 tie_fixed,
	input  wire logic [NUM_PORTS-1:0] green_strap,
	input  wire logic [NUM_PORTS-1:0] amber_strap,
	input  wire logic [NUM_PORTS-1:0] green_oe_n,
	input  wire logic [NUM_PORTS-1:0] amber_oe_n,
	output logic      [NUM_PORTS-1:0] dplus,
	output logic      [NUM_PORTS-1:0] dminus,
	output logic      [NUM_PORTS-1:0] green_pin,
	output logic      [NUM_PORTS-1:0] amber_pin
);
	// Unused ports are tied high from port seven down; ports one and two may
	// also be tied high, which the device must not take as a disable.
	assign dplus  = ~(7'h7F >> n_off) | {5'h00, {2{tie_fixed}}};
	assign dminus = ~(7'h7F >> n_off) | {5'h00, {2{tie_fixed}}};
	// A released pin rests at its strap level; a driven pin is pulled low.
	assign green_pin = green_oe_n & green_strap;
	assign amber_pin = amber_oe_n & amber_strap;
endmodule : board_model

// ---- tb_hub_strap_and_led_indicators.sv ----
// Self-checking bench for the hub strap and indicator block.
// Assumes a 20-cycle blink so that the link LED tests stay short.
`timescale 1ns/100ps

module tb_hub_strap_and_led_indicators
	import hub_strap_pkg::*;
;
	localparam int BL = 20; // Shortened blink length.
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 0, avs_readdata, q, d;
	logic avs_waitrequest, link_activity_led_n_o, link_activity_led_n_oe_n;
	logic no_overcurrent_select = 0, overcurrent_analog_select = 0, overcurrent_analog_mode;
	logic hub_configured = 0, hub_suspended = 0, host_transaction = 0, tie = 0;
	logic [6:0] overcurrent_sense_n = 7'h7F, port_dplus_line, port_dminus_line;
	logic [6:0] port_green_led_n_i, port_green_led_n_o, port_green_led_n_oe_n, gs = 0;
	logic [6:0] port_amber_led_n_i, port_amber_led_n_o, port_amber_led_n_oe_n, as_ = 0;
	logic [6:0] overcurrent_flags, en, e7;
	logic [2:0] n_off = 0;
	int fails = 0, n_compared = 0, cyc = 0, c, r;
	integer seed;

	always #12.5 clk = ~clk;

	hub_strap_and_led_indicators #(.BLINK_LEN(BL)) i_dut (.clk, .rst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .no_overcurrent_select, .overcurrent_analog_select,
		.overcurrent_sense_n, .port_dplus_line, .port_dminus_line, .hub_configured,
		.hub_suspended, .host_transaction, .port_green_led_n_i, .port_green_led_n_o,
		.port_green_led_n_oe_n, .port_amber_led_n_i, .port_amber_led_n_o,
		.port_amber_led_n_oe_n, .link_activity_led_n_o, .link_activity_led_n_oe_n,
		.overcurrent_flags, .overcurrent_analog_mode);

	board_model i_board (.n_off(n_off), .tie_fixed(tie), .green_strap(gs), .amber_strap(as_),
		.green_oe_n(port_green_led_n_oe_n), .amber_oe_n(port_amber_led_n_oe_n),
		.dplus(port_dplus_line), .dminus(port_dminus_line),
		.green_pin(port_green_led_n_i), .amber_pin(port_amber_led_n_i));

	// Expected strap status word, built from the chosen straps.
	function automatic logic [31:0] exp_stat(input logic [2:0] n, input logic no, an,
		input logic [6:0] g, a);
		exp_stat = {1'b0, a, 1'b0, g, 1'b0, 1'b1, an, no, 1'b0, 3'(3'd7 - n), 1'b0, 7'h7F >> n};
	endfunction : exp_stat

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// One Avalon access; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= wd;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// One transaction pulse, then count the cycles the link LED stays dark.
	task automatic blink;
		@(posedge clk);
		host_transaction <= 1'b1;
		@(posedge clk);
		host_transaction <= 1'b0;
		c = 0;
		@(negedge clk);
		while (link_activity_led_n_oe_n === 1'b1 && c < 99)
		begin
			c++;
			@(negedge clk);
		end
	endtask : blink

	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// A hang is cut short well above the expected run length.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			results();
		end
	end

	// Two passes, each with a fresh reset and new random straps.
	initial
	begin
		seed = 32'h3F13;
		for (r = 0; r < 2; r++)
		begin
			@(posedge clk);
			rst <= 1'b1;
			hub_configured <= 1'b0;
			hub_suspended <= 1'b0;
			no_overcurrent_select <= r[0];
			overcurrent_analog_select <= 1'($random(seed));
			n_off <= 3'({$random(seed)} % 6);
			gs <= 7'($random(seed));
			as_ <= 7'($random(seed));
			tie <= 1'($random(seed));
			repeat (4) @(posedge clk);
			rst <= 1'b0;
			repeat (2) @(posedge clk);
			en = 7'h7F >> n_off;
			chk("link dark", 1, link_activity_led_n_oe_n);
			chk("leds off", 14'h3FFF, {port_green_led_n_oe_n, port_amber_led_n_oe_n});
			chk("pins low", 0, {port_green_led_n_o, port_amber_led_n_o});
			chk("link pin low", 0, link_activity_led_n_o);
			bus(0, STRAP_STAT_OFS, 0);
			chk("strap", exp_stat(n_off, r[0], overcurrent_analog_select, gs, as_), q);
			chk("analog", overcurrent_analog_select, overcurrent_analog_mode);
			bus(0, 4'hC, 0);
			chk("unmapped", 0, q);
			d = $random(seed);
			bus(1, LED_CTRL_OFS, d);
			bus(0, LED_CTRL_OFS, 0);
			chk("ctrl", d, q);
			e7 = ~(en & d[6:0]);
			chk("green", e7, port_green_led_n_oe_n);
			e7 = ~(en & d[14:8]);
			chk("amber", e7, port_amber_led_n_oe_n);
			@(posedge clk);
			overcurrent_sense_n <= 7'($random(seed));
			repeat (3) @(posedge clk);
			bus(0, OC_STAT_OFS, 0);
			e7 = r[0] ? 7'h00 : (~overcurrent_sense_n & en);
			chk("oc stat", e7, q);
			chk("oc flags", e7, overcurrent_flags);
			hub_configured <= 1'b1;
			repeat (3) @(posedge clk);
			chk("link on", 0, link_activity_led_n_oe_n);
			blink();
			chk("blink", BL, c);
			@(posedge clk);
			host_transaction <= 1'b1;
			@(posedge clk);
			host_transaction <= 1'b0;
			// The next pulse lands mid-blink and must restart the full interval.
			repeat (8) @(posedge clk);
			blink();
			chk("restart", BL, c);
			@(posedge clk);
			hub_suspended <= 1'b1;
			blink();
			chk("suspend", 99, c);
			$display("test %0d done", r);
		end
		results();
	end
endmodule : tb_hub_strap_and_led_indicators
